// file: rtl/ssp_fifo.sv
/*
 synchronous queue with valid/ready on both sides.
 assumes DEPTH is a power of two; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module ssp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ssp_fifo_t;

   ssp_fifo_t s_reg;
   ssp_fifo_t s_next;
   logic push;
   logic pop;

   assign in_ready_o = (s_reg.cnt != FULL_CNT);
   assign out_valid_o = (s_reg.cnt != '0);
   assign out_data_o = s_reg.mem[s_reg.rp];

   always_comb begin
      s_next = s_reg;
      push = in_valid_i & in_ready_o;
      pop = out_valid_o & out_ready_i;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data_i;
         s_next.wp = s_reg.wp + AW'(1);
      end
      if (pop) begin
         s_next.rp = s_reg.rp + AW'(1);
      end
      if (push & !pop) begin
         s_next.cnt = s_reg.cnt + (AW + 1)'(1);
      end else if (pop & !push) begin
         s_next.cnt = s_reg.cnt - (AW + 1)'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   a_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i) s_reg.cnt <= FULL_CNT)
      else $error("queue count above depth");
   a_fifo_full_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!in_ready_o && !out_ready_i) |=> (!in_ready_o && $stable(s_reg.wp)))
      else $error("full queue took a word");
endmodule

// file: rtl/ssp_pkg.sv
/*
 constants, field layouts and enumerations of the synchronous serial port.
 assumes a 32-bit classic wishbone master and a 10 MHz system clock.
*/
package ssp_pkg;

   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_W = 3;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_PRE = 8'h0C;
   localparam logic [7:0] OFS_DIV = 8'h10;

   localparam int CTRL_SIZE_LSB = 0;
   localparam int CTRL_SIZE_MSB = 3;
   localparam int CTRL_FMT_LSB = 4;
   localparam int CTRL_FMT_MSB = 5;
   localparam int CTRL_POL = 6;
   localparam int CTRL_PHA = 7;
   localparam int CTRL_MST = 8;
   localparam int CTRL_SOD = 9;
   localparam int CTRL_EN = 10;

   localparam int STAT_TXE = 0;
   localparam int STAT_TNF = 1;
   localparam int STAT_RNE = 2;
   localparam int STAT_RFF = 3;
   localparam int STAT_BSY = 4;
   localparam int STAT_OVR = 5;

   localparam logic [3:0] RST_SIZE_M1 = 4'h7;
   localparam logic [3:0] SIZE_M1_MIN = 4'h3;
   localparam logic [7:0] RST_PRE = 8'h02;
   localparam logic [7:0] PRE_MIN = 8'h02;
   localparam logic [7:0] RST_DIV = 8'h00;

   typedef enum logic [1:0] {
      SSP_FMT_SPI = 2'b00,
      SSP_FMT_CMD = 2'b01,
      SSP_FMT_SSF = 2'b10
   } ssp_fmt_t;

   typedef enum logic [1:0] {
      SSP_ST_IDLE = 2'b00,
      SSP_ST_ACTIVE = 2'b01,
      SSP_ST_GAP = 2'b10
   } ssp_st_t;

   // clock periods of a whole frame: command format sends, waits one bit, receives
   function automatic logic [5:0] ssp_total(input logic [1:0] fmt, input logic [3:0] size_m1);
      logic [4:0] size;
      size = {1'b0, size_m1} + 5'h01;
      ssp_total = (fmt == SSP_FMT_CMD) ? {size, 1'b1} : {1'b0, size};
   endfunction

endpackage

// file: rtl/ssp_top.sv
/*
 synchronous serial port: wishbone registers, clock generation, frame engine
 for master and slave, transmit and receive queues.
 assumes a classic wishbone master on clk_i; pins from outside are asynchronous.
*/
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module ssp_top
   import ssp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe_o,
   input wire logic fss_i,
   output logic fss_o,
   output logic fss_oe_o,
   output logic txd_o,
   output logic txd_oe_o,
   input wire logic rxd_i
);

   typedef struct packed {
      logic [3:0] size_m1;
      logic [1:0] fmt;
      logic pol;
      logic pha;
      logic master;
      logic sod;
      logic en;
      logic [7:0] pre;
      logic [7:0] div;
      logic ack;
      logic [31:0] rdata;
      logic [6:0] pre_cnt;
      logic [7:0] div_cnt;
      ssp_st_t st;
      logic [15:0] sh;
      logic [5:0] bcnt;
      logic sclk;
      logic fss;
      logic txd;
      logic txd_oe;
      logic sclk_oe;
      logic fss_oe;
      logic [SYNC_W-1:0] sy_sclk;
      logic [SYNC_W-1:0] sy_fss;
      logic [SYNC_W-1:0] sy_rxd;
      logic f_sclk;
      logic f_fss;
      logic f_rxd;
      logic ovr;
   } ssp_state_t;

   ssp_state_t s_reg;
   ssp_state_t s_next;

   logic tx_push;
   logic tx_ready;
   logic tx_valid;
   logic [15:0] tx_word;
   logic tx_pop;
   logic rx_push;
   logic rx_ready;
   logic rx_valid;
   logic [15:0] rx_head;
   logic rx_pop;
   logic [15:0] rx_word;
   logic half_tick;
   logic lead;
   logic trail;
   logic bus_req;
   logic pha_eff;
   logic pol_eff;
   logic rxbit;
   logic [5:0] total;
   logic [4:0] size;

   ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(tx_push),
      .in_data_i(wb_dat_i[15:0]),
      .in_ready_o(tx_ready),
      .out_valid_o(tx_valid),
      .out_data_o(tx_word),
      .out_ready_i(tx_pop)
   );

   ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(rx_push),
      .in_data_i(rx_word),
      .in_ready_o(rx_ready),
      .out_valid_o(rx_valid),
      .out_data_o(rx_head),
      .out_ready_i(rx_pop)
   );

   assign wb_dat_o = s_reg.rdata;
   assign wb_ack_o = s_reg.ack;
   assign sclk_o = s_reg.sclk;
   assign sclk_oe_o = s_reg.sclk_oe;
   assign fss_o = s_reg.fss;
   assign fss_oe_o = s_reg.fss_oe;
   assign txd_o = s_reg.txd;
   assign txd_oe_o = s_reg.txd_oe;

   always_comb begin
      s_next = s_reg;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      half_tick = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      size = {1'b0, s_reg.size_m1} + 5'h01;
      total = ssp_total(s_reg.fmt, s_reg.size_m1);
      // only spi lets software pick the clock shape; the other two are fixed
      pha_eff = (s_reg.fmt == SSP_FMT_SPI) ? s_reg.pha : (s_reg.fmt == SSP_FMT_SSF);
      pol_eff = (s_reg.fmt == SSP_FMT_SPI) ? s_reg.pol : 1'b0;

      // pin inputs: a level counts once the last two stages agree
      s_next.sy_sclk = {s_reg.sy_sclk[SYNC_W-2:0], sclk_i};
      s_next.sy_fss = {s_reg.sy_fss[SYNC_W-2:0], fss_i};
      s_next.sy_rxd = {s_reg.sy_rxd[SYNC_W-2:0], rxd_i};
      if (s_reg.sy_sclk[1] == s_reg.sy_sclk[2]) begin
         s_next.f_sclk = s_reg.sy_sclk[2];
      end
      if (s_reg.sy_fss[1] == s_reg.sy_fss[2]) begin
         s_next.f_fss = s_reg.sy_fss[2];
      end
      if (s_reg.sy_rxd[1] == s_reg.sy_rxd[2]) begin
         s_next.f_rxd = s_reg.sy_rxd[2];
      end
      rxbit = s_reg.f_rxd;

      // wishbone slave: one wait state, ack for exactly one cycle
      bus_req = wb_cyc_i & wb_stb_i & !s_reg.ack;
      s_next.ack = bus_req;
      if (bus_req) begin
         s_next.rdata = '0;
         if (wb_adr_i == OFS_CTRL) begin
            if (wb_we_i & wb_sel_i[0]) begin
               // shorter lengths are raised to the four-bit minimum
               s_next.size_m1 = (wb_dat_i[CTRL_SIZE_MSB:CTRL_SIZE_LSB] < SIZE_M1_MIN) ?
                  SIZE_M1_MIN : wb_dat_i[CTRL_SIZE_MSB:CTRL_SIZE_LSB];
               s_next.fmt = wb_dat_i[CTRL_FMT_MSB:CTRL_FMT_LSB];
               s_next.pol = wb_dat_i[CTRL_POL];
               s_next.pha = wb_dat_i[CTRL_PHA];
            end
            if (wb_we_i & wb_sel_i[1]) begin
               s_next.master = wb_dat_i[CTRL_MST];
               s_next.sod = wb_dat_i[CTRL_SOD];
               s_next.en = wb_dat_i[CTRL_EN];
            end
            s_next.rdata[CTRL_SIZE_MSB:CTRL_SIZE_LSB] = s_reg.size_m1;
            s_next.rdata[CTRL_FMT_MSB:CTRL_FMT_LSB] = s_reg.fmt;
            s_next.rdata[CTRL_POL] = s_reg.pol;
            s_next.rdata[CTRL_PHA] = s_reg.pha;
            s_next.rdata[CTRL_MST] = s_reg.master;
            s_next.rdata[CTRL_SOD] = s_reg.sod;
            s_next.rdata[CTRL_EN] = s_reg.en;
         end else if (wb_adr_i == OFS_DATA) begin
            if (wb_we_i) begin
               // a write to a full queue is dropped; status shows it beforehand
               tx_push = |wb_sel_i[1:0];
            end else begin
               rx_pop = rx_valid;
               s_next.rdata[15:0] = rx_valid ? rx_head : 16'h0000;
            end
         end else if (wb_adr_i == OFS_STAT) begin
            s_next.rdata[STAT_TXE] = !tx_valid;
            s_next.rdata[STAT_TNF] = tx_ready;
            s_next.rdata[STAT_RNE] = rx_valid;
            s_next.rdata[STAT_RFF] = !rx_ready;
            s_next.rdata[STAT_BSY] = (s_reg.st != SSP_ST_IDLE);
            s_next.rdata[STAT_OVR] = s_reg.ovr;
            if (wb_we_i & wb_sel_i[0] & wb_dat_i[STAT_OVR]) begin
               s_next.ovr = 1'b0;
            end
         end else if (wb_adr_i == OFS_PRE) begin
            if (wb_we_i & wb_sel_i[0]) begin
               // odd values lose bit 0 so each half period is whole
               s_next.pre = ({wb_dat_i[7:1], 1'b0} < PRE_MIN) ? PRE_MIN :
                  {wb_dat_i[7:1], 1'b0};
            end
            s_next.rdata[7:0] = s_reg.pre;
         end else if (wb_adr_i == OFS_DIV) begin
            if (wb_we_i & wb_sel_i[0]) begin
               s_next.div = wb_dat_i[7:0];
            end
            s_next.rdata[7:0] = s_reg.div;
         end
      end

      // bit clock: prescaler feeds divider; each divider wrap is half a bit
      if (s_reg.en & s_reg.master & (s_reg.st != SSP_ST_IDLE)) begin
         if (s_reg.pre_cnt == (s_reg.pre[7:1] - 7'h01)) begin
            s_next.pre_cnt = '0;
            if (s_reg.div_cnt == s_reg.div) begin
               s_next.div_cnt = '0;
               half_tick = 1'b1;
            end else begin
               s_next.div_cnt = s_reg.div_cnt + 8'h01;
            end
         end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 7'h01;
         end
      end else begin
         s_next.pre_cnt = '0;
         s_next.div_cnt = '0;
      end

      case (s_reg.st)
         SSP_ST_IDLE: begin
            s_next.bcnt = '0;
            s_next.sclk = pol_eff;
            s_next.fss = (s_reg.fmt != SSP_FMT_SSF);
            if (s_reg.en & s_reg.master & tx_valid & rx_ready) begin
               tx_pop = 1'b1;
               s_next.sh = tx_word;
               s_next.st = SSP_ST_ACTIVE;
               // spi and command frames hold select low; the pulse format pulses high
               s_next.fss = (s_reg.fmt == SSP_FMT_SSF);
               if (!pha_eff) begin
                  s_next.txd = tx_word[s_reg.size_m1];
               end
            end else if (s_reg.en & !s_reg.master & (s_reg.f_fss == (s_reg.fmt == SSP_FMT_SSF))) begin
               // a slave with nothing queued answers with zeros
               tx_pop = tx_valid;
               s_next.sh = tx_valid ? tx_word : 16'h0000;
               s_next.st = SSP_ST_ACTIVE;
               if (!pha_eff) begin
                  s_next.txd = tx_valid ? tx_word[s_reg.size_m1] : 1'b0;
               end
            end
         end
         SSP_ST_ACTIVE: begin
            if (s_reg.master) begin
               if (half_tick) begin
                  s_next.sclk = !s_reg.sclk;
                  lead = (s_reg.sclk == pol_eff);
                  trail = !lead;
                  if (s_reg.fmt == SSP_FMT_SSF) begin
                     s_next.fss = 1'b0;
                  end
               end
            end else begin
               lead = (s_next.f_sclk != s_reg.f_sclk) & (s_next.f_sclk != pol_eff);
               trail = (s_next.f_sclk != s_reg.f_sclk) & (s_next.f_sclk == pol_eff);
               // in spi and command formats a select released in mid-frame abandons the frame
               if ((s_reg.fmt != SSP_FMT_SSF) & s_reg.f_fss) begin
                  s_next.st = SSP_ST_IDLE;
                  lead = 1'b0;
                  trail = 1'b0;
               end
            end
            if (!s_reg.en) begin
               s_next.st = SSP_ST_IDLE;
               lead = 1'b0;
               trail = 1'b0;
            end
            // one shift register serves both ways: sample shifts in at bit 0
            if ((lead & pha_eff) | (trail & !pha_eff & (s_reg.bcnt != total - 6'h01))) begin
               s_next.txd = ((trail ? s_reg.bcnt + 6'h01 : s_reg.bcnt) < {1'b0, size}) ?
                  s_reg.sh[s_reg.size_m1] : 1'b0;
            end
            if ((lead & !pha_eff) | (trail & pha_eff)) begin
               s_next.sh = {s_reg.sh[14:0], rxbit};
            end
            if (trail) begin
               s_next.bcnt = s_reg.bcnt + 6'h01;
               if (s_reg.bcnt == total - 6'h01) begin
                  rx_push = rx_ready;
                  if (!rx_ready) begin
                     s_next.ovr = 1'b1;
                  end
                  s_next.st = s_reg.master ? SSP_ST_GAP : SSP_ST_IDLE;
                  s_next.fss = (s_reg.fmt != SSP_FMT_SSF);
               end
            end
         end
         SSP_ST_GAP: begin
            // idle half bit between frames lets a slave see select rise
            if (half_tick | !s_reg.en) begin
               s_next.st = SSP_ST_IDLE;
            end
         end
         default: begin
            s_next.st = SSP_ST_IDLE;
         end
      endcase

      rx_word = s_next.sh & (16'hFFFF >> (4'hF - s_reg.size_m1));
      s_next.sclk_oe = s_reg.en & s_reg.master;
      s_next.fss_oe = s_reg.en & s_reg.master;
      s_next.txd_oe = s_reg.en & (s_reg.master | ((s_next.st == SSP_ST_ACTIVE) & !s_reg.sod));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.size_m1 <= RST_SIZE_M1;
         s_reg.pre <= RST_PRE;
         s_reg.div <= RST_DIV;
         s_reg.sclk <= 1'b0;
         s_reg.fss <= 1'b1;
         s_reg.f_fss <= 1'b1;
         s_reg.sy_fss <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence frame_start_s;
      s_reg.master && s_reg.st == SSP_ST_IDLE && s_next.st == SSP_ST_ACTIVE;
   endsequence

   a_master_pins_driven: assert property (s_reg.en && s_reg.master |=> sclk_oe_o && fss_oe_o)
      else $error("master not driving clock and frame");
   // the pulse must end at the first divider tick, whatever the programmed bit rate
   a_ssf_pulse_one: assert property (s_reg.master && s_reg.fmt == SSP_FMT_SSF &&
      s_reg.st == SSP_ST_ACTIVE && half_tick |=> !fss_o)
      else $error("frame pulse did not end");
   a_frame_bit_count: assert property (rx_push |-> s_reg.bcnt == total - 6'h01)
      else $error("frame pushed at wrong bit count");
   a_tx_msb_first: assert property (frame_start_s ##0 !pha_eff |=>
      txd_o == $past(tx_word[s_reg.size_m1]))
      else $error("first bit is not the top bit");
   a_slave_pins_free: assert property (s_reg.en && !s_reg.master |=> !sclk_oe_o && !fss_oe_o)
      else $error("slave drives clock or frame");
   a_slave_out_off: assert property (s_reg.en && !s_reg.master && s_reg.sod |=> !txd_oe_o)
      else $error("disabled slave output driven");
   a_clock_from_divider: assert property (s_reg.master && s_reg.st == SSP_ST_ACTIVE &&
      !half_tick && s_reg.en |=> $stable(sclk_o))
      else $error("serial clock moved without divider tick");
   a_no_frame_empty: assert property (s_reg.master && s_reg.st == SSP_ST_IDLE && !tx_valid
      |=> s_reg.st == SSP_ST_IDLE)
      else $error("frame started with empty queue");
endmodule

// file: verification/ssp_peer.sv
/*
 serial peripheral model: answers the port as slave or acts as master towards it.
 assumes clock polarity 0 and a port clock no faster than clk/8 in either role.
*/
`timescale 1ns/1ps
module ssp_peer (
   input wire logic clk_i,
   input wire logic sclk_i,
   input wire logic fss_i,
   input wire logic txd_i,
   input wire logic pha_i,
   input wire logic pulse_i,
   input wire logic [5:0] tot_i,
   input wire logic [15:0] reply_i,
   input wire logic go_i,
   output logic rxd_o,
   output logic sclk_m_o,
   output logic fss_m_o,
   output logic busy_o
);
   logic s_q = 1'b0;
   logic f_q = 1'b1;
   logic act = 1'b0;
   logic tg = 1'b0;
   logic [32:0] osr = '0;
   logic [32:0] isr = '0;
   logic [9:0] mc = '0;
   logic [9:0] ph;
   logic [5:0] n = '0;
   logic [32:0] log_q[$];
   assign ph = (mc - 10'h001) >> 3;
   // line has no pull: outside a frame it changes every clock
   assign rxd_o = act ? osr[32] : tg;
   // master role: select low for the frame, clock idles low, 8 clocks a half bit
   assign fss_m_o = (mc == 10'h000);
   assign sclk_m_o = (mc != 10'h000) && ph[0] && (ph < {3'h0, tot_i, 1'b0});
   assign busy_o = act || (mc != 10'h000);
   always @(posedge clk_i) begin
      s_q <= sclk_i;
      f_q <= fss_i;
      tg <= ~tg;
      if (go_i || mc != 10'h000) begin
         mc <= (mc == {tot_i, 4'h0} + 10'h010) ? 10'h000 : mc + 10'h001;
      end
      // reply is aligned so that the last tot bits carry it, msb first
      if ((!pulse_i && f_q && !fss_i) || (pulse_i && !f_q && fss_i)) begin
         osr <= ({17'h0, reply_i} << (6'h21 - tot_i)) >> pha_i;
         isr <= '0;
         n <= '0;
         act <= 1'b1;
      end else if (act && sclk_i != s_q) begin
         if (sclk_i == pha_i) begin
            osr <= osr << 1;
         end else begin
            isr <= {isr[31:0], txd_i};
            n <= n + 6'h01;
            if (n + 6'h01 == tot_i) begin
               act <= 1'b0;
               log_q.push_back({isr[31:0], txd_i});
            end
         end
      end
   end
endmodule

// file: verification/sync_serial_port_test.sv
/*
 self-checking bench of the synchronous serial port: bus tasks, peer model, tests.
 assumes a one-cycle bus answer and the register layout of the package.
*/
`timescale 1ns/1ps
module sync_serial_port_test import ssp_pkg::*;;
   localparam logic [1:0] T_FMT [5] = '{SSP_FMT_SPI, SSP_FMT_CMD, SSP_FMT_SSF,
                                        SSP_FMT_CMD, SSP_FMT_SPI};
   localparam int T_SZ [5] = '{4, 16, 16, 4, 16};
   localparam int T_PRE [5] = '{6, 4, 4, 6, 4};
   localparam int T_DIV [5] = '{1, 3, 3, 1, 3};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr = '0;
   logic [31:0] wb_wdat = '0;
   logic [31:0] wb_rdat;
   logic [3:0] wb_sel = '0;
   logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_ack;
   logic d_sclk, d_sclk_oe, d_fss, d_fss_oe, d_txd, d_txd_oe, rxd, sclk_m, fss_m, p_busy;
   logic p_pha = 1'b0, p_pulse = 1'b0, p_go = 1'b0, oe_seen = 1'b0, fss_q = 1'b1;
   logic [5:0] p_tot = 6'h08;
   logic [15:0] p_reply = '0;
   int err_total = 0, num_checks = 0, cyc_cnt = 0, nfr = 0, hi_run = 0, hi_len = 0;
   wire sclk_w = d_sclk_oe ? d_sclk : sclk_m;
   wire fss_w = d_fss_oe ? d_fss : fss_m;
   // an undriven data line must not look like the last bit
   wire txd_w = d_txd_oe ? d_txd : cyc_cnt[0];

   ssp_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .sclk_i(sclk_w), .sclk_o(d_sclk),
      .sclk_oe_o(d_sclk_oe), .fss_i(fss_w), .fss_o(d_fss), .fss_oe_o(d_fss_oe),
      .txd_o(d_txd), .txd_oe_o(d_txd_oe), .rxd_i(rxd));
   ssp_peer peer (.clk_i(clk_i), .sclk_i(sclk_w), .fss_i(fss_w), .txd_i(txd_w),
      .pha_i(p_pha), .pulse_i(p_pulse), .tot_i(p_tot), .reply_i(p_reply), .go_i(p_go),
      .rxd_o(rxd), .sclk_m_o(sclk_m), .fss_m_o(fss_m), .busy_o(p_busy));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      fss_q <= d_fss;
      if (fss_q && !d_fss && d_fss_oe) nfr <= nfr + 1;
      hi_run <= d_sclk ? hi_run + 1 : 0;
      if (!d_sclk && hi_run != 0) hi_len <= hi_run;
      if (d_txd_oe === 1'b1) oe_seen <= 1'b1;
      if (cyc_cnt == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hF;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   // waits until the queue is drained, the engine and the peer are idle
   task automatic wait_idle();
      logic [31:0] st;
      st = 32'h10;
      repeat (4) @(posedge clk_i);
      while (st[STAT_BSY] !== 1'b0 || st[STAT_TXE] !== 1'b1 || p_busy !== 1'b0) begin
         wb(1'b0, OFS_STAT, 32'h0, st);
      end
      repeat (8) @(posedge clk_i);
   endtask

   task automatic peer_go();
      p_go <= 1'b1;
      @(posedge clk_i);
      p_go <= 1'b0;
      wait_idle();
   endtask

   function automatic logic [31:0] cw(input logic [1:0] f, input int sz, input logic m,
                                      input logic s, input logic e);
      return {21'h0, e, s, m, 2'b00, f, 4'(sz - 1)};
   endfunction

   initial begin
      int i, sz, tot;
      logic [31:0] m;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(OFS_CTRL, {28'h0, RST_SIZE_M1});
      rdc(OFS_PRE, {24'h0, RST_PRE});
      rdc(OFS_DIV, {24'h0, RST_DIV});
      rdc(OFS_STAT, 32'h3);
      rdc(8'h14, 32'h0);
      check({30'h0, d_sclk_oe, d_txd_oe}, 32'h0);
      wr(OFS_PRE, 32'h4);
      wr(OFS_DIV, 32'h3);
      wr(OFS_CTRL, cw(SSP_FMT_SPI, 8, 1'b1, 1'b0, 1'b0));
      // nine words while disabled: the ninth finds the queue full
      for (i = 0; i < 9; i++) wr(OFS_DATA, 32'hA0 + i);
      rdc(OFS_STAT, 32'h0);
      p_reply <= 16'h00C3;
      wr(OFS_CTRL, cw(SSP_FMT_SPI, 8, 1'b1, 1'b0, 1'b1));
      wait_idle();
      check(nfr, 32'h8);
      rdc(OFS_STAT, 32'hF);
      check({30'h0, d_sclk_oe, d_fss_oe}, 32'h3);
      check(hi_len, 32'h8);
      for (i = 0; i < 8; i++) begin
         check(32'(peer.log_q.pop_front()), 32'hA0 + i);
         rdc(OFS_DATA, 32'hC3);
      end
      rdc(OFS_DATA, 32'h0);
      for (i = 0; i < 5; i++) begin
         sz = T_SZ[i];
         m = (32'h1 << sz) - 32'h1;
         tot = (T_FMT[i] == SSP_FMT_CMD) ? 2 * sz + 1 : sz;
         p_tot <= 6'(tot);
         p_pha <= (T_FMT[i] == SSP_FMT_SSF);
         p_pulse <= (T_FMT[i] == SSP_FMT_SSF);
         p_reply <= 16'(32'h2E19 & m);
         wr(OFS_PRE, T_PRE[i]);
         wr(OFS_DIV, T_DIV[i]);
         wr(OFS_CTRL, cw(T_FMT[i], sz, 1'b1, 1'b0, 1'b1));
         wr(OFS_DATA, 32'hB5C7 & m);
         wait_idle();
         check(32'(peer.log_q.pop_front() >> (tot - sz)) & m, 32'hB5C7 & m);
         rdc(OFS_DATA, 32'h2E19 & m);
         check(hi_len, T_PRE[i] / 2 * (T_DIV[i] + 1));
      end
      // a size below four is raised to four
      wr(OFS_CTRL, cw(SSP_FMT_SPI, 3, 1'b0, 1'b0, 1'b0));
      rdc(OFS_CTRL, 32'h3);
      p_tot <= 6'h10;
      p_pha <= 1'b0;
      p_pulse <= 1'b0;
      p_reply <= 16'h2BD4;
      wr(OFS_CTRL, cw(SSP_FMT_SPI, 16, 1'b0, 1'b0, 1'b1));
      wr(OFS_DATA, 32'h9E61);
      peer_go();
      check(32'(peer.log_q.pop_front()), 32'h9E61);
      rdc(OFS_DATA, 32'h2BD4);
      check({30'h0, oe_seen, d_sclk_oe}, 32'h2);
      oe_seen <= 1'b0;
      wr(OFS_CTRL, cw(SSP_FMT_SPI, 16, 1'b0, 1'b1, 1'b1));
      wr(OFS_DATA, 32'h1234);
      peer_go();
      check({31'h0, oe_seen}, 32'h0);
      rdc(OFS_DATA, 32'h2BD4);
      print_verdict();
   end
endmodule
